//--- rtl/spwm_map.svh
// register offsets, field positions, reset values and counts of the pwm channel
`ifndef SPWM_MAP_SVH
`define SPWM_MAP_SVH

// channel registers, one byte each
`define SPWM_ADDR_MODCTL 8'h00
`define SPWM_ADDR_DUTY_LOAD 8'h01
`define SPWM_ADDR_DUTY_ACTIVE 8'h02
`define SPWM_ADDR_TSEL 8'h03
`define SPWM_ADDR_PIN_DIR 8'h04
`define SPWM_ADDR_TMR_NUM 8'h05

// timer k occupies four bytes at 4*(SPWM_TMR_WORD_BASE + k)
`define SPWM_TMR_WORD_BASE 6'h02
`define SPWM_TMR_SUB_PERIOD 2'h0
`define SPWM_TMR_SUB_CTL 2'h1
`define SPWM_TMR_SUB_COUNT 2'h2
`define SPWM_TMR_SUB_FLAG 2'h3

// module_control fields
`define SPWM_MOD_OFF 4'h0
`define SPWM_MOD_PWM_TOP 2'h3
`define SPWM_DUTY_LOW_HI 5
`define SPWM_DUTY_LOW_LO 4

// timer control fields
`define SPWM_CTL_RUN_BIT 2
`define SPWM_PS_DIV1 2'h0
`define SPWM_PS_DIV4 2'h1

// fine counter wrap points: four core clocks per step times the prescale ratio
`define SPWM_FINE_MAX_DIV1 6'h03
`define SPWM_FINE_MAX_DIV4 6'h0F
`define SPWM_FINE_MAX_DIV16 6'h3F

// reset values
`define SPWM_RST_PERIOD 8'hFF
`define SPWM_RST_BYTE 8'h00
`define SPWM_RST_PIN_DIR 1'h1
`define SPWM_NO_TIMER 8'h00

`endif

//--- rtl/spwm_pkg.sv
// types shared by the standard pwm channel
package spwm_pkg;

  // module_control as software sees it
  typedef struct packed {
    logic [1:0] dutyLow;
    logic [3:0] mode;
  } spwm_modctl_t;

  // control byte of one base timer
  typedef struct packed {
    logic run;
    logic [1:0] prescale;
  } spwm_tmrctl_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spwm_bus_t;

endpackage

//--- rtl/spwm_channel.sv
// standard pwm channel with its three selectable 8-bit base timers
//
// Behaviour
// - period is (period_limit+1)*4*prescale core clocks
// - match then next step: clear counter, pin high
// - zero duty keeps pin low at period start
// - period end copies buffered duty into active
// - duty is duty_load:duty_low_bits, ten bits
// - in pwm mode duty writes take effect only at period end
// - duty_active read-only while in pwm mode
// - active byte plus hidden 2-bit latch
// - time base is counter plus two phase bits
// - time base equals duty: pin low
// - high time is duty*prescale core clocks
// - duty beyond period leaves pin unchanged
// - resolution log2(4*(period+1)), ten bits max
// - no postscaler affects the period
// - timer_choice picks one of several counters
// - counter pairings depend on channel number
// - prescale ratios 1, 4 and 16 only
// - sleep freezes counter, state and pin
// - counting resumes after sleep without reset
// - zero module_control releases the pin
// - mode zero switches off, clears duty latch and level
// - reset restores registers, pin made input
`timescale 1ns/1ns
`include "spwm_map.svh"

module spwm_channel #(
  parameter int CHANNEL = 1,
  parameter int NUM_TIMERS = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sleepReq,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [7:0] busRdata,
  output logic pwmPin,
  output logic pwmPinOe,
  output logic timerMatchAny
);

  // the choice field is two bits wide and the map holds three timers
  if (NUM_TIMERS != 3) begin : g_bad_timers
    $error("spwm_channel: NUM_TIMERS must be 3");
  end
  if (CHANNEL < 1 || CHANNEL > 10) begin : g_bad_channel
    $error("spwm_channel: CHANNEL must lie in 1..10");
  end

  // counter number behind each choice, fixed by channel group
  function automatic logic [7:0] timer_number(input int ch, input int slot);
    logic [7:0] num;
    num = 8'h02;
    if (slot == 1) begin
      num = (ch <= 4) ? 8'h04 : (ch <= 7) ? 8'h06 : 8'h08;
    end else if (slot == 2) begin
      num = (ch <= 4) ? 8'h06 : (ch <= 7) ? 8'h08 : 8'h0A;
    end
    return num;
  endfunction

  spwm_pkg::spwm_bus_t bus;
  assign bus.wr = busWr;
  assign bus.rd = busRd;
  assign bus.addr = busAddr;
  assign bus.wdata = busWdata;

  // channel registers
  spwm_pkg::spwm_modctl_t mod_reg;
  logic [7:0] dutyLoad_reg;
  logic [7:0] dutyActive_reg;
  logic [7:0] dutyActive_next;
  logic [1:0] dutyLatch_reg;
  logic [1:0] dutyLatch_next;
  logic [1:0] timerChoice_reg;
  logic pinDir_reg;
  logic level_reg;
  logic level_next;
  logic pinOut_reg;
  logic pinOe_reg;
  logic [7:0] rdData_reg;
  logic matchAny_reg;

  // per-timer views gathered from the generate loop
  logic [7:0] periodW [NUM_TIMERS];
  logic [7:0] countW [NUM_TIMERS];
  logic [7:0] countNextW [NUM_TIMERS];
  logic [2:0] ctlW [NUM_TIMERS];
  logic [1:0] extW [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] flagW;
  logic [NUM_TIMERS-1:0] periodEndW;

  // address decode
  wire hitMod = bus.addr == `SPWM_ADDR_MODCTL;
  wire hitLoad = bus.addr == `SPWM_ADDR_DUTY_LOAD;
  wire hitActive = bus.addr == `SPWM_ADDR_DUTY_ACTIVE;
  wire hitTsel = bus.addr == `SPWM_ADDR_TSEL;
  wire hitDir = bus.addr == `SPWM_ADDR_PIN_DIR;
  wire hitNum = bus.addr == `SPWM_ADDR_TMR_NUM;
  wire [5:0] tmrWord = bus.addr[7:2] - `SPWM_TMR_WORD_BASE;
  wire [1:0] tmrSub = bus.addr[1:0];
  wire hitTmr = (bus.addr[7:2] >= `SPWM_TMR_WORD_BASE) && (tmrWord < 6'(NUM_TIMERS));
  wire [1:0] tmrIdx = tmrWord[1:0];

  // mode decode
  wire modeOff = mod_reg.mode == `SPWM_MOD_OFF;
  wire pwmMode = mod_reg.mode[3:2] == `SPWM_MOD_PWM_TOP;
  wire frozen = sleepReq;

  // selected timer; an unused choice code gives no events
  wire selValid = timerChoice_reg < 2'(NUM_TIMERS);
  wire [1:0] sel = selValid ? timerChoice_reg : 2'h0;
  wire selEnd = selValid && periodEndW[sel];
  // time base after the coming edge, so the registered pin falls right on the duty
  wire [9:0] timeBase = {countNextW[sel], extW[sel]};
  wire [9:0] dutyBuffered = {dutyLoad_reg, mod_reg.dutyLow};
  wire [9:0] dutyLatched = {dutyActive_reg, dutyLatch_reg};
  wire dutyMatch = selValid && (timeBase == dutyLatched);

  generate
    for (genvar k = 0; k < NUM_TIMERS; k++) begin : g_tmr
      spwm_pkg::spwm_tmrctl_t ctl_reg;
      logic [7:0] period_reg;
      logic [7:0] count_reg;
      logic [5:0] fine_reg;
      logic flag_reg;

      // only three ratios exist; code 2 and 3 both mean 1:16
      wire [5:0] fineMax = (ctl_reg.prescale == `SPWM_PS_DIV1) ? `SPWM_FINE_MAX_DIV1 :
                           (ctl_reg.prescale == `SPWM_PS_DIV4) ? `SPWM_FINE_MAX_DIV4 :
                           `SPWM_FINE_MAX_DIV16;
      wire step = ctl_reg.run && !frozen && (fine_reg == fineMax);
      wire atLimit = count_reg == period_reg;
      wire periodEnd = step && atLimit;
      wire wrHere = bus.wr && hitTmr && (tmrIdx == 2'(k));
      wire clrFlag = wrHere && (tmrSub == `SPWM_TMR_SUB_FLAG) && bus.wdata[0];
      // counter position after the coming edge; held while stopped or asleep
      wire [5:0] fineNext = !(ctl_reg.run && !frozen) ? fine_reg :
                            step ? 6'h00 : fine_reg + 6'h01;
      wire [7:0] countNext = !step ? count_reg : atLimit ? 8'h00 : count_reg + 8'h01;
      // phase bits: core clock phase at 1:1, else the top prescaler bits
      wire [1:0] ext = (ctl_reg.prescale == `SPWM_PS_DIV1) ? fineNext[1:0] :
                       (ctl_reg.prescale == `SPWM_PS_DIV4) ? fineNext[3:2] :
                       fineNext[5:4];

      // timer registers; the period has no postscaler in its path
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ctl_reg <= '0;
          period_reg <= `SPWM_RST_PERIOD;
        end else if (wrHere && tmrSub == `SPWM_TMR_SUB_CTL) begin
          ctl_reg <= bus.wdata[2:0];
        end else if (wrHere && tmrSub == `SPWM_TMR_SUB_PERIOD) begin
          period_reg <= bus.wdata;
        end
      end

      // counting; sleep holds every bit so wake-up resumes in place
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          count_reg <= `SPWM_RST_BYTE;
          fine_reg <= '0;
        end else if (wrHere && tmrSub == `SPWM_TMR_SUB_COUNT) begin
          count_reg <= bus.wdata;
          fine_reg <= '0;
        end else if (ctl_reg.run && !frozen) begin
          fine_reg <= step ? 6'h00 : fine_reg + 6'h01;
          if (step) begin
            count_reg <= atLimit ? 8'h00 : count_reg + 8'h01;
          end
        end
      end

      // match flag: a new match beats a clear in the same cycle
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flag_reg <= 1'b0;
        end else begin
          flag_reg <= periodEnd | (flag_reg & ~clrFlag);
        end
      end

      assign periodW[k] = period_reg;
      assign countW[k] = count_reg;
      assign countNextW[k] = countNext;
      assign ctlW[k] = ctl_reg;
      assign extW[k] = ext;
      assign flagW[k] = flag_reg;
      assign periodEndW[k] = periodEnd;
    end
  endgenerate

  // duty buffer and pin level; match at period end outranks the clear match
  always_comb begin
    dutyActive_next = dutyActive_reg;
    dutyLatch_next = dutyLatch_reg;
    level_next = level_reg;
    if (modeOff) begin
      dutyLatch_next = 2'h0;
      level_next = 1'b0;
    end else if (pwmMode && !frozen) begin
      if (selEnd) begin
        dutyActive_next = dutyLoad_reg;
        dutyLatch_next = mod_reg.dutyLow;
        level_next = dutyBuffered != 10'h000;
      end else if (dutyMatch) begin
        // a duty above the count range never matches, so the pin stays
        level_next = 1'b0;
      end
    end
    if (!pwmMode && bus.wr && hitActive) begin
      dutyActive_next = bus.wdata;
    end
  end

  // software-written channel registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mod_reg <= '0;
      dutyLoad_reg <= `SPWM_RST_BYTE;
      timerChoice_reg <= 2'h0;
      pinDir_reg <= `SPWM_RST_PIN_DIR;
    end else if (bus.wr) begin
      if (hitMod) begin
        mod_reg <= bus.wdata[`SPWM_DUTY_LOW_HI:0];
      end
      if (hitLoad) begin
        dutyLoad_reg <= bus.wdata;
      end
      if (hitTsel) begin
        timerChoice_reg <= bus.wdata[1:0];
      end
      if (hitDir) begin
        pinDir_reg <= bus.wdata[0];
      end
    end
  end

  // hidden duty state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dutyActive_reg <= `SPWM_RST_BYTE;
      dutyLatch_reg <= 2'h0;
      level_reg <= 1'b0;
    end else begin
      dutyActive_reg <= dutyActive_next;
      dutyLatch_reg <= dutyLatch_next;
      level_reg <= level_next;
    end
  end

  // pin drive: only in pwm mode with the direction bit cleared
  wire pinOe_next = pwmMode && !pinDir_reg;
  wire pinOut_next = pinOe_next && level_next;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut_reg <= 1'b0;
      pinOe_reg <= 1'b0;
      matchAny_reg <= 1'b0;
    end else begin
      pinOut_reg <= pinOut_next;
      pinOe_reg <= pinOe_next;
      matchAny_reg <= |flagW;
    end
  end

  // read mux; unmapped addresses and reserved bits read as zero
  wire [7:0] modRead = {2'h0, mod_reg};
  wire [7:0] tmrRead =
    (tmrSub == `SPWM_TMR_SUB_PERIOD) ? periodW[tmrIdx] :
    (tmrSub == `SPWM_TMR_SUB_CTL) ? {5'h00, ctlW[tmrIdx]} :
    (tmrSub == `SPWM_TMR_SUB_COUNT) ? countW[tmrIdx] :
    {7'h00, flagW[tmrIdx]};
  wire [7:0] numRead = selValid ? timer_number(CHANNEL, int'(sel)) : `SPWM_NO_TIMER;
  wire [7:0] readMux =
    hitMod ? modRead :
    hitLoad ? dutyLoad_reg :
    hitActive ? dutyActive_reg :
    hitTsel ? {6'h00, timerChoice_reg} :
    hitDir ? {7'h00, pinDir_reg} :
    hitNum ? numRead :
    hitTmr ? tmrRead :
    8'h00;

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= bus.rd ? readMux : 8'h00;
    end
  end

  assign busRdata = rdData_reg;
  assign pwmPin = pinOut_reg;
  assign pwmPinOe = pinOe_reg;
  assign timerMatchAny = matchAny_reg;

endmodule // spwm_channel

//--- tb/spwm_channel_properties.sv
// port checker of the pwm channel
`timescale 1ns/1ns
module spwm_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic sleepReq,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic [7:0] busRdata,
  input wire logic pwmPin,
  input wire logic pwmPinOe,
  input wire logic timerMatchAny
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // read data stand one cycle only
  a_rdata_idle: assert property (!$past(busRd) |-> busRdata == 8'h00)
    else $error("read data outside slot");
  a_unmapped_zero: assert property ($past(busRd) && ($past(busAddr) inside {8'h06, 8'h07}
    || $past(busAddr) > 8'h13) |-> busRdata == 8'h00) else $error("unmapped read not zero");
  a_idle_pin_low: assert property (!pwmPinOe |-> !pwmPin)
    else $error("pin driven high while released");
  a_oe_after_write: assert property ($changed(pwmPinOe) |-> $past(busWr) || $past(busWr, 2))
    else $error("enable moved without a write");
  // the match flag output follows the rise of a new period by one cycle
  a_rise_with_match: assert property ($rose(pwmPin) && $past(pwmPinOe) |=> timerMatchAny)
    else $error("pin rose without period end");
  // two cycles of sleep: state sampled after the first is frozen
  a_sleep_pin: assert property (sleepReq [*2] |=> $stable(pwmPin))
    else $error("pin moved in sleep");
  a_sleep_flag: assert property (sleepReq [*2] |=> $stable(timerMatchAny))
    else $error("flag moved in sleep");
  a_flag_clear: assert property ($fell(timerMatchAny) |-> $past(busWr, 2) || $past(busWr, 3))
    else $error("flag cleared without a write");
  c_rise: cover property ($rose(pwmPin));
  c_sleep: cover property (sleepReq [*2]);
  c_release: cover property ($fell(pwmPinOe));
endmodule // spwm_props

bind spwm_channel spwm_props i_props (.clk, .rst, .sleepReq, .busAddr, .busWdata, .busWr,
  .busRd, .busRdata, .pwmPin, .pwmPinOe, .timerMatchAny);

//--- tb/spwm_load.sv
// load on the pwm pin, measures period and high time
`timescale 1ns/1ns
module spwm_load (
  input wire logic clk,
  input wire logic pwmPin,
  input wire logic pwmPinOe,
  output int lastHigh,
  output int lastPeriod,
  output int rises
);
  int hiCnt = 0;
  int perCnt = 0;
  logic prevLevel = 1'b0;
  // pull-down holds the line low while the channel releases it
  wire logic pinLevel = pwmPinOe ? pwmPin : 1'b0;
  // rise to rise is one period, high cycles counted within
  always @(posedge clk) begin
    prevLevel <= pinLevel;
    if (pinLevel && !prevLevel) begin
      lastPeriod <= perCnt;
      lastHigh <= hiCnt;
      rises <= rises + 1;
      perCnt <= 1;
      hiCnt <= 1;
    end else begin
      perCnt <= perCnt + 1;
      hiCnt <= hiCnt + int'(pinLevel);
    end
  end
endmodule // spwm_load

//--- tb/spwm_channel_tb.sv
// self-checking bench of the standard pwm channel
`timescale 1ns/1ns
module spwm_channel_tb;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sleepReq = 1'b0;
  logic [7:0] busAddr = 8'h00;
  logic [7:0] busWdata = 8'h00;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic [7:0] busRdata;
  logic pwmPin;
  logic pwmPinOe;
  logic timerMatchAny;
  logic [7:0] rv;
  logic [7:0] hold8;
  int lastHigh;
  int lastPeriod;
  int rises;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int pr;
  int duty;
  int psv;
  int r;
  // address and reset value pairs, then counter numbers per choice
  logic [7:0] rAdr [6] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h08, 8'h06};
  logic [7:0] rExp [6] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'hFF, 8'h00};
  logic [7:0] tExp [4] = '{8'h02, 8'h04, 8'h06, 8'h00};
  spwm_channel i_dut (.clk, .rst, .sleepReq, .busAddr, .busWdata, .busWr, .busRd,
    .busRdata, .pwmPin, .pwmPinOe, .timerMatchAny);
  spwm_load i_load (.clk, .pwmPin, .pwmPinOe, .lastHigh, .lastPeriod, .rises);
  initial begin
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge clk);
    busWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busRd <= 1'b0;
    #1 rv = busRdata;
  endtask
  // stop and zero timer 0 first, so a shorter period never waits for wrap
  task automatic setup(input int d, input logic [1:0] ps);
    wr(8'h09, 8'h00);
    wr(8'h0A, 8'h00);
    wr(8'h04, 8'h01);
    wr(8'h08, 8'(pr));
    wr(8'h00, {2'h0, 2'(d), 4'hC});
    wr(8'h01, 8'(d >> 2));
    wr(8'h03, 8'h00);
    wr(8'h0B, 8'h01);
    wr(8'h09, {5'h00, 1'b1, ps});
    rv = 8'h00;
    for (int i = 0; i < 400 && rv[0] !== 1'b1; i++) rd(8'h0B);
    `CHK(rv[0], 1'b1)
    wr(8'h04, 8'h00);
  endtask
  // first rise may be partial, the third closes a full period
  task automatic measure();
    r = rises;
    for (int i = 0; i < 3000 && rises < r + 3; i++) @(posedge clk);
    #1;
    `CHK(lastPeriod, (pr + 1) * 4 * psv)
    `CHK(lastHigh, duty * psv)
  endtask
  initial begin
    void'($urandom(78));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(rAdr[i]);
      `CHK(rv, rExp[i])
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h03, 8'(c));
      rd(8'h05);
      `CHK(rv, tExp[c])
    end
    $display("test reset and choice done");
    for (int ps = 0; ps < 4; ps++) begin
      pr = 3 + $urandom % 5;
      duty = 2 + $urandom % (4 * (pr + 1) - 2);
      psv = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
      setup(duty, 2'(ps));
      measure();
      wr(8'h02, 8'hA5);
      rd(8'h02);
      `CHK(rv, 8'(duty >> 2))
      $display("test prescale %0d done", ps);
    end
    // new duty written just after a rise must wait for the next period
    r = rises;
    for (int i = 0; i < 3000 && rises <= r; i++) @(posedge clk);
    wr(8'h01, 8'((duty ^ 1) >> 2));
    wr(8'h00, {2'h0, 2'(duty ^ 1), 4'hC});
    for (int i = 0; i < 3000 && rises <= r + 1; i++) @(posedge clk);
    #1;
    `CHK(lastHigh, duty * psv)
    duty = duty ^ 1;
    measure();
    $display("test buffered duty done");
    @(posedge clk);
    sleepReq <= 1'b1;
    rd(8'h0A);
    hold8 = rv;
    repeat (40) @(posedge clk);
    rd(8'h0A);
    `CHK(rv, hold8)
    @(posedge clk);
    sleepReq <= 1'b0;
    measure();
    $display("test sleep done");
    for (int k = 0; k < 2; k++) begin
      setup(k * (4 * (pr + 1) + 1), 2'h2);
      repeat (3 * (pr + 1) * 64) @(posedge clk);
      #1;
      `CHK(pwmPin, 1'(k))
    end
    wr(8'h00, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    `CHK(pwmPinOe, 1'b0)
    $display("test zero and release done");
    wrap_up();
  end
endmodule // spwm_channel_tb
